// ==== testbench/remote_peer.sv ====
// remote serial peer: sends frames on rxd, collects whole frames from txd
`timescale 1ns/100ps
module remote_peer (
   // line
   input wire clk,
   input wire txd,
   output reg rxd
);
   reg [7:0] got[$];
   reg [7:0] sh;
   integer i;
   // receiver samples mid-bit, drops frames with a low stop bit
   initial begin
      rxd = 1'b1;
      forever begin
         @(negedge txd);
         repeat (24) @(posedge clk);
         for (i = 0; i < 8; i = i + 1) begin
            sh[i] = txd;
            repeat (16) @(posedge clk);
         end
         if (txd)
            got.push_back(sh);
         else
            wait (txd);
      end
   end
   // one frame plus idle bit, or eleven low bits as break
   task send(input [7:0] d, input brk);
      reg [10:0] f;
      integer k;
      begin
         f = brk ? 11'h000 : {2'h3, d, 1'b0};
         @(posedge clk);
         for (k = 0; k < 11; k = k + 1) begin
            rxd <= f[k];
            repeat (16) @(posedge clk);
         end
         rxd <= 1'b1;
         @(posedge clk);
      end
   endtask
endmodule

// ==== testbench/uart_flow_control_status_chk.sv ====
// port checker for the flow-controlled serial port
`timescale 1ns/100ps
module uart_flow_control_status_chk (
   // apb
   input wire pclk,
   input wire presetn,
   input wire [11:0] paddr,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   // line and handshake
   input wire rxd,
   input wire txd,
   input wire cts,
   input wire rts,
   input wire rts_oe
);
   reg [15:0] ctl_r;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // shadow of the control word from completed writes
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         ctl_r <= 16'h0080;
      else if (psel && penable && pready && pwrite && paddr == 12'h004)
         ctl_r <= pwdata[15:0];
   end
   property p_rdy_pulse;
      pready |=> !pready;
   endproperty
   a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready longer than one cycle");
   property p_rdy_acc;
      pready |-> psel && penable && $past(psel && penable);
   endproperty
   a_rdy_acc: assert property (p_rdy_acc) else $error("pready outside second access cycle");
   property p_err_map;
      pready && (paddr > 12'h018 || paddr[1:0] != 2'h0) |-> pslverr;
   endproperty
   a_err_map: assert property (p_err_map) else $error("unmapped address not refused");
   property p_err_ok;
      pslverr |-> pready && prdata == 32'h0;
   endproperty
   a_err_ok: assert property (p_err_ok) else $error("refusal without pready or with data");
   property p_rd_hold;
      !pready |-> $stable(prdata);
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved between answers");
   property p_oe_hold;
      $changed(rts_oe) |-> $past(pready && pwrite && paddr == 12'h004, 2) || $past(!presetn, 2);
   endproperty
   a_oe_hold: assert property (p_oe_hold) else $error("handshake enable moved without write");
   property p_man_rts;
      !ctl_r[0] && $stable(ctl_r) && $past(presetn) |-> rts == ctl_r[5];
   endproperty
   a_man_rts: assert property (p_man_rts) else $error("manual request level not on pin");
   property p_brk_low;
      ctl_r[6] && $past(ctl_r[6]) && $past(ctl_r[6], 2) |-> !txd;
   endproperty
   a_brk_low: assert property (p_brk_low) else $error("line not low during break");
   property p_txd_bit;
      $fell(txd) |=> !txd [*8];
   endproperty
   a_txd_bit: assert property (p_txd_bit) else $error("start bit too short");
endmodule
bind uart_flow_control_status uart_flow_control_status_chk uart_flow_control_status_chk_inst (.pclk(pclk),
   .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd), .cts(cts), .rts(rts),
   .rts_oe(rts_oe));

// ==== testbench/uart_flow_control_status_tb_top.sv ====
// self-checking bench for the flow-controlled serial port
`timescale 1ns/100ps
`include "uart_flow_defs.vh"
module uart_flow_control_status_tb_top;
   reg pclk, presetn, psel, penable, pwrite, cts, ev;
   reg [11:0] paddr;
   reg [31:0] pwdata, rv, seed;
   wire [31:0] prdata;
   wire pready, pslverr, rxd, txd, rts, rts_oe;
   reg [7:0] tq[$];
   reg [7:0] rq[$];
   integer error_cnt, num_checks, c, i;
   uart_flow_control_status uart_flow_control_status_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rxd(rxd), .txd(txd), .cts(cts), .rts(rts), .rts_oe(rts_oe));
   remote_peer remote_peer_inst (.clk(pclk), .txd(txd), .rxd(rxd));
   function [31:0] xs(input [31:0] s);
      reg [31:0] x;
      begin
         x = s ^ (s << 13);
         x = x ^ (x >> 17);
         xs = x ^ (x << 5);
      end
   endfunction
   function [31:0] thr(input [1:0] k);
      thr = k == 2'h0 ? 32'h8 : k == 2'h1 ? 32'hb : k == 2'h2 ? 32'hd : 32'hf;
   endfunction
   task chk(input [31:0] s, input [31:0] e);
      begin
         num_checks = num_checks + 1;
         if (s !== e) begin
            error_cnt = error_cnt + 1;
            $display("mismatch at %0t: seen %h expected %h", $time, s, e);
         end
      end
   endtask
   // one apb transfer, waits for pready
   task apb(input w, input [11:0] a, input [31:0] d);
      integer n;
      begin
         @(posedge pclk);
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge pclk);
         penable <= 1'b1;
         n = 0;
         @(posedge pclk);
         while (pready !== 1'b1 && n < 50) begin
            @(posedge pclk);
            n = n + 1;
         end
         if (n == 50)
            error_cnt = error_cnt + 1;
         rv = prdata;
         ev = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   task txb;
      begin
         seed = xs(seed);
         tq.push_back(seed[7:0]);
         apb(1'b1, `ADDR_DATA, {24'h0, seed[7:0]});
      end
   endtask
   task rxb;
      begin
         seed = xs(seed);
         rq.push_back(seed[7:0]);
         remote_peer_inst.send(seed[7:0], 1'b0);
      end
   endtask
   task end_of_test;
      begin
         $display("checks %0d mismatches %0d", num_checks, error_cnt);
         if (error_cnt == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
         else
            $display("CHECKS NOT OK");
         $finish;
      end
   endtask
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   // watchdog
   initial begin
      repeat (60000) @(posedge pclk);
      error_cnt = error_cnt + 1;
      end_of_test;
   end
   initial begin
      {presetn, psel, penable, pwrite, cts} = 5'h0;
      paddr = 12'h0;
      pwdata = 32'h0;
      error_cnt = 0;
      num_checks = 0;
      seed = 32'hd4e6c529;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `ADDR_CTRL, 32'h0);
      chk(rv, 32'h80);
      chk(rts_oe, 1);
      chk(rts, 0);
      // two-wire: handshake pin released
      apb(1'b1, `ADDR_CTRL, 32'h0);
      repeat (3) @(posedge pclk);
      chk(rts_oe, 0);
      apb(1'b1, `ADDR_CTRL, 32'hb0);
      repeat (3) @(posedge pclk);
      chk(rts, 1);
      apb(1'b0, 12'h01c, 32'h0);
      chk(ev, 1);
      // held transmit under automatic clear
      apb(1'b1, `ADDR_CTRL, 32'h92);
      for (i = 0; i < 3; i = i + 1)
         txb;
      repeat (200) @(posedge pclk);
      chk(txd, 1);
      apb(1'b0, `ADDR_LEVEL, 32'h0);
      chk(rv, 32'h300);
      cts <= 1'b1;
      repeat (700) @(posedge pclk);
      apb(1'b0, `ADDR_LINE, 32'h0);
      chk(rv & 32'h60, 32'h60);
      // automatic request at every threshold code
      for (c = 0; c < 4; c = c + 1) begin
         apb(1'b1, `ADDR_CTRL, 32'h391 | (c << 2));
         apb(1'b1, `ADDR_FLUSH, 32'h2);
         apb(1'b0, `ADDR_CTRL, 32'h0);
         chk(rv, 32'h91 | (c << 2));
         rq.delete();
         for (i = 0; i < thr(c); i = i + 1) begin
            rxb;
            chk(rts, i + 1 < thr(c));
         end
         apb(1'b0, `ADDR_DATA, 32'h0);
         chk(rv, rq.pop_front());
         repeat (3) @(posedge pclk);
         chk(rts, 1);
      end
      for (i = 0; i < 3; i = i + 1)
         rxb;
      apb(1'b0, `ADDR_LEVEL, 32'h0);
      chk(rv & 32'h1f, 32'h10);
      apb(1'b0, `ADDR_LINE, 32'h0);
      chk(rv & 32'h3, 32'h3);
      apb(1'b0, `ADDR_LINE, 32'h0);
      chk(rv & 32'h3, 32'h1);
      apb(1'b1, `ADDR_FLUSH, 32'h3);
      apb(1'b0, `ADDR_LINE, 32'h0);
      chk(rv & 32'h1, 32'h0);
      // received break and line status source
      remote_peer_inst.send(8'h0, 1'b1);
      apb(1'b1, `ADDR_CTRL, 32'h4080);
      apb(1'b0, `ADDR_IDENT, 32'h0);
      chk(rv, 32'h6);
      apb(1'b0, `ADDR_LINE, 32'h0);
      chk(rv & 32'h91, 32'h90);
      apb(1'b0, `ADDR_LINE, 32'h0);
      chk(rv & 32'h90, 32'h0);
      apb(1'b0, `ADDR_IDENT, 32'h0);
      chk(rv, 32'h1);
      // modem status and its source
      apb(1'b0, `ADDR_MODEM, 32'h0);
      chk(rv & 32'h11, 32'h11);
      apb(1'b1, `ADDR_CTRL, 32'h8080);
      cts <= 1'b0;
      repeat (8) @(posedge pclk);
      apb(1'b0, `ADDR_IDENT, 32'h0);
      chk(rv, 32'h0);
      apb(1'b0, `ADDR_MODEM, 32'h0);
      chk(rv & 32'h11, 32'h1);
      apb(1'b1, `ADDR_CTRL, 32'hb080);
      apb(1'b0, `ADDR_IDENT, 32'h0);
      chk(rv, 32'h2);
      rxb;
      apb(1'b0, `ADDR_IDENT, 32'h0);
      chk(rv, 32'h4);
      apb(1'b1, `ADDR_CTRL, 32'h1180);
      apb(1'b0, `ADDR_IDENT, 32'h0);
      chk(rv, 32'h1);
      repeat (720) @(posedge pclk);
      apb(1'b0, `ADDR_IDENT, 32'h0);
      chk(rv, 32'hc);
      for (i = 0; i < 3; i = i + 1)
         rxb;
      apb(1'b0, `ADDR_IDENT, 32'h0);
      chk(rv, 32'h4);
      // even parity on receive, peer sends a high parity bit
      apb(1'b1, `ADDR_CTRL, 32'h480);
      rxb;
      apb(1'b0, `ADDR_LINE, 32'h0);
      chk(rv & 32'h84, ^seed[7:0] ? 32'h0 : 32'h84);
      // break in mid-character, then resume
      apb(1'b1, `ADDR_CTRL, 32'h80);
      for (i = 0; i < 3; i = i + 1)
         txb;
      tq.delete(3);
      repeat (30) @(posedge pclk);
      apb(1'b1, `ADDR_CTRL, 32'hc0);
      repeat (400) @(posedge pclk);
      chk(txd, 0);
      apb(1'b1, `ADDR_CTRL, 32'h80);
      repeat (700) @(posedge pclk);
      chk(remote_peer_inst.got.size(), 5);
      for (i = 0; i < 5; i = i + 1)
         chk(remote_peer_inst.got[i], tq[i]);
      end_of_test;
   end
endmodule

// ==== verilog/uart_flow_control_status.v ====
// serial port with fifos, automatic request/clear handshake, break, line and modem status
// Operation
// - auto request drops at threshold, returns below
// - threshold codes select 8, 11, 13, 15
// - auto clear gates start of each character
// - polarity bit chooses active level of handshake
// - polarity ignored when automatic handshake off
// - manual request level drives request pin directly
// - break aborts current character, stops sending
// - break release resumes sending queued bytes
// - separate flushes empty fifos, shifter unaffected
// - any flush resets receive trigger to one
// - receive and transmit fill counts are readable
// - line status read clears error flags only
// - error summary on parity, framing or break
// - shifter empty and transmit fifo empty flags
// - break flag on whole low frame
// - overrun when character arrives to full fifo
// - data ready while receive fifo not empty
// - modem bit 4 level, bit 0 change
// - ident reports one source, bit 0 low pending
// - source codes 3,2,6,1,0 in priority order
// - written bytes sent in order from fifo
// - data read pops one receive byte
// - receive available at trigger 1,4,8,14
// - four-wire default, option releases request pin
`timescale 1ns/100ps
`include "uart_flow_defs.vh"
module uart_flow_control_status (
   // apb slave
   input wire pclk,
   input wire presetn,
   input wire [11:0] paddr,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // serial line
   input wire rxd,
   output reg txd,
   // handshake
   input wire cts,
   output reg rts,
   output reg rts_oe
);
   localparam TX_IDLE = 2'b01;
   localparam TX_SHIFT = 2'b10;
   localparam RX_HUNT = 3'b001;
   localparam RX_IDLE = 3'b010;
   localparam RX_BITS = 3'b100;

   // auto request threshold decode
   function [4:0] req_level;
      input [1:0] sel;
      begin
         case (sel)
            2'b00: req_level = 5'd8;
            2'b01: req_level = 5'd11;
            2'b10: req_level = 5'd13;
            default: req_level = 5'd15;
         endcase
      end
   endfunction

   // receive trigger decode
   function [4:0] trig_level;
      input [1:0] sel;
      begin
         case (sel)
            2'b00: trig_level = 5'd1;
            2'b01: trig_level = 5'd4;
            2'b10: trig_level = 5'd8;
            default: trig_level = 5'd14;
         endcase
      end
   endfunction

   reg [15:0] ctrl_r;
   reg [7:0] tx_mem [0:15];
   reg [7:0] rx_mem [0:15];
   reg [3:0] tx_wp_r, tx_rp_r, rx_wp_r, rx_rp_r;
   reg [4:0] tx_cnt_r, rx_cnt_r;
   reg [2:0] rx_q_r, cts_q_r;
   reg rx_s_r, cts_s_r, cts_prev_r;
   reg oe_r, pe_r, fe_r, bi_r, err_r, dcts_r;
   reg [1:0] tx_st_r;
   reg [10:0] tx_sh_r;
   reg [3:0] tx_idx_r;
   reg [4:0] tx_tmr_r;
   reg [2:0] rx_st_r;
   reg [9:0] rx_sh_r;
   reg [3:0] rx_idx_r;
   reg [4:0] rx_tmr_r;
   reg [9:0] to_cnt_r;
   reg [31:0] rd_mux;
   reg mapped;
   reg [2:0] irq_code;
   reg irq_any;

   wire par_en = ctrl_r[`CTL_PAR];
   wire brk = ctrl_r[`CTL_BRK];
   wire acc = psel & penable & pready;
   wire wr_hit = acc & pwrite;
   wire rd_hit = acc & ~pwrite;
   wire flush_wr = wr_hit & (paddr == `ADDR_FLUSH);
   wire tx_flush = flush_wr & pwdata[`FL_TX];
   wire rx_flush = flush_wr & pwdata[`FL_RX];
   wire ls_rd = rd_hit & (paddr == `ADDR_LINE);
   wire ms_rd = rd_hit & (paddr == `ADDR_MODEM);
   wire tx_push = wr_hit & (paddr == `ADDR_DATA) & (tx_cnt_r != `FIFO_DEPTH) & ~tx_flush;
   wire rx_pop = rd_hit & (paddr == `ADDR_DATA) & (rx_cnt_r != 5'd0) & ~rx_flush;
   // handshake levels through the polarity setting
   wire cts_act = ctrl_r[`CTL_POL] ? cts_s_r : ~cts_s_r;
   wire req_below = rx_cnt_r < req_level(ctrl_r[`CTL_THR+1:`CTL_THR]);
   wire tx_start = (tx_st_r == TX_IDLE) & (tx_cnt_r != 5'd0) & ~brk &
                   (~ctrl_r[`CTL_ACLR] | cts_act);
   wire [3:0] tx_last = par_en ? 4'd10 : 4'd9;
   // receive frame completion and its verdicts
   wire [3:0] rx_last = par_en ? 4'd10 : 4'd9;
   wire rx_done = (rx_st_r == RX_BITS) & (rx_tmr_r == 5'd0) & (rx_idx_r == rx_last);
   wire [9:0] rx_full = par_en ? {rx_s_r, rx_sh_r[9:1]} : {rx_s_r, rx_sh_r[9:1]} >> 1;
   wire [7:0] rx_byte = rx_full[7:0];
   wire rx_stop = rx_s_r;
   wire ev_bi = rx_done & (par_en ? ({rx_s_r, rx_sh_r[9:1]} == 10'h000)
                                  : ({rx_s_r, rx_sh_r[9:2]} == 9'h000));
   wire ev_fe = rx_done & ~rx_stop & ~ev_bi;
   wire ev_pe = rx_done & par_en & ~ev_bi & (^rx_byte ^ rx_full[8]);
   wire rx_push_ok = rx_done & ~ev_bi & ~rx_flush;
   wire rx_push = rx_push_ok & (rx_cnt_r != `FIFO_DEPTH);
   wire ev_oe = rx_push_ok & (rx_cnt_r == `FIFO_DEPTH);
   wire [4:0] trig = trig_level(ctrl_r[`CTL_TRIG+1:`CTL_TRIG]);
   wire to_hit = (to_cnt_r == `TO_CYC) & (rx_cnt_r != 5'd0) & (rx_cnt_r < trig);

   // input synchronisers, a change counts once the last two stages agree
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_q_r <= 3'h7;
         cts_q_r <= 3'h7;
         rx_s_r <= 1'b1;
         cts_s_r <= 1'b1;
         cts_prev_r <= 1'b1;
      end else begin
         rx_q_r <= {rx_q_r[1:0], rxd};
         cts_q_r <= {cts_q_r[1:0], cts};
         if (rx_q_r[1] == rx_q_r[2]) begin
            rx_s_r <= rx_q_r[2];
         end
         if (cts_q_r[1] == cts_q_r[2]) begin
            cts_s_r <= cts_q_r[2];
         end
         cts_prev_r <= cts_s_r;
      end
   end

   // read data, decode and pending source selection
   always @* begin
      irq_any = 1'b1;
      irq_code = `IRQ_MODEM;
      if (ctrl_r[`CTL_IE_LINE] & (oe_r | pe_r | fe_r | bi_r)) begin
         irq_code = `IRQ_LINE;
      end else if (ctrl_r[`CTL_IE_RX] & (rx_cnt_r >= trig)) begin
         irq_code = `IRQ_RXAV;
      end else if (ctrl_r[`CTL_IE_RX] & to_hit) begin
         irq_code = `IRQ_TOUT;
      end else if (ctrl_r[`CTL_IE_TX] & (tx_cnt_r == 5'd0)) begin
         irq_code = `IRQ_TXE;
      end else if (ctrl_r[`CTL_IE_MODEM] & dcts_r) begin
         irq_code = `IRQ_MODEM;
      end else begin
         irq_any = 1'b0;
      end
      mapped = 1'b1;
      rd_mux = 32'h0000_0000;
      if (paddr == `ADDR_DATA) begin
         rd_mux[7:0] = rx_mem[rx_rp_r];
      end else if (paddr == `ADDR_CTRL) begin
         rd_mux[15:0] = ctrl_r;
      end else if (paddr == `ADDR_FLUSH) begin
         rd_mux = 32'h0000_0000;
      end else if (paddr == `ADDR_LINE) begin
         rd_mux[`LS_ERR] = err_r;
         rd_mux[`LS_TEMT] = (tx_st_r == TX_IDLE);
         rd_mux[`LS_THRE] = (tx_cnt_r == 5'd0);
         rd_mux[`LS_BI] = bi_r;
         rd_mux[`LS_FE] = fe_r;
         rd_mux[`LS_PE] = pe_r;
         rd_mux[`LS_OE] = oe_r;
         rd_mux[`LS_DR] = (rx_cnt_r != 5'd0);
      end else if (paddr == `ADDR_MODEM) begin
         rd_mux[`MS_CTS] = cts_s_r;
         rd_mux[`MS_DCTS] = dcts_r;
      end else if (paddr == `ADDR_IDENT) begin
         rd_mux[3:0] = {irq_code, ~irq_any};
      end else if (paddr == `ADDR_LEVEL) begin
         rd_mux[4:0] = rx_cnt_r;
         rd_mux[12:8] = tx_cnt_r;
      end else begin
         mapped = 1'b0;
      end
   end

   // apb answer one cycle into the access phase
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else if (psel & penable & ~pready) begin
         pready <= 1'b1;
         pslverr <= ~mapped;
         prdata <= rd_mux;
      end else begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   // control word, flush forces the trigger back to one byte
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= `CTRL_RST;
      end else if (wr_hit & (paddr == `ADDR_CTRL)) begin
         ctrl_r <= pwdata[15:0];
      end else if (flush_wr & (pwdata[`FL_TX] | pwdata[`FL_RX])) begin
         ctrl_r[`CTL_TRIG+1:`CTL_TRIG] <= 2'b00;
      end
   end

   // sticky status, events win over the clearing read
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         oe_r <= 1'b0;
         pe_r <= 1'b0;
         fe_r <= 1'b0;
         bi_r <= 1'b0;
         err_r <= 1'b0;
         dcts_r <= 1'b0;
      end else begin
         oe_r <= (oe_r & ~(ls_rd & prdata[`LS_OE])) | ev_oe;
         pe_r <= (pe_r & ~(ls_rd & prdata[`LS_PE])) | ev_pe;
         fe_r <= (fe_r & ~(ls_rd & prdata[`LS_FE])) | ev_fe;
         bi_r <= (bi_r & ~(ls_rd & prdata[`LS_BI])) | ev_bi;
         err_r <= (err_r & ~(ls_rd & prdata[`LS_ERR])) | ev_pe | ev_fe | ev_bi;
         dcts_r <= (dcts_r & ~(ms_rd & prdata[`MS_DCTS])) | (cts_s_r ^ cts_prev_r);
      end
   end

   // transmit fifo, bytes leave in write order
   always @(posedge pclk) begin
      if (tx_push) begin
         tx_mem[tx_wp_r] <= pwdata[7:0];
      end
   end
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_wp_r <= 4'h0;
         tx_rp_r <= 4'h0;
         tx_cnt_r <= 5'h00;
      end else if (tx_flush) begin
         tx_wp_r <= 4'h0;
         tx_rp_r <= 4'h0;
         tx_cnt_r <= 5'h00;
      end else begin
         tx_wp_r <= tx_wp_r + {3'h0, tx_push};
         tx_rp_r <= tx_rp_r + {3'h0, tx_start};
         tx_cnt_r <= tx_cnt_r + {4'h0, tx_push} - {4'h0, tx_start};
      end
   end

   // receive fifo and its idle timer
   always @(posedge pclk) begin
      if (rx_push) begin
         rx_mem[rx_wp_r] <= rx_byte;
      end
   end
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_wp_r <= 4'h0;
         rx_rp_r <= 4'h0;
         rx_cnt_r <= 5'h00;
         to_cnt_r <= 10'h000;
      end else begin
         if (rx_flush) begin
            rx_wp_r <= 4'h0;
            rx_rp_r <= 4'h0;
            rx_cnt_r <= 5'h00;
         end else begin
            rx_wp_r <= rx_wp_r + {3'h0, rx_push};
            rx_rp_r <= rx_rp_r + {3'h0, rx_pop};
            rx_cnt_r <= rx_cnt_r + {4'h0, rx_push} - {4'h0, rx_pop};
         end
         if (rx_push | rx_pop | (rx_cnt_r == 5'd0)) begin
            to_cnt_r <= 10'h000;
         end else if (to_cnt_r != `TO_CYC) begin
            to_cnt_r <= to_cnt_r + 10'h001;
         end
      end
   end

   // transmit shifter: start, data, optional even parity, stop
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_st_r <= TX_IDLE;
         tx_sh_r <= 11'h7ff;
         tx_idx_r <= 4'h0;
         tx_tmr_r <= 5'h00;
         txd <= 1'b1;
      end else begin
         txd <= ~brk & ((tx_st_r == TX_SHIFT) ? tx_sh_r[0] : 1'b1);
         case (tx_st_r)
            TX_IDLE: begin
               if (tx_start) begin
                  tx_st_r <= TX_SHIFT;
                  tx_idx_r <= 4'h0;
                  tx_tmr_r <= `BIT_LAST;
                  tx_sh_r <= par_en ? {1'b1, ^tx_mem[tx_rp_r], tx_mem[tx_rp_r], 1'b0}
                                    : {2'b11, tx_mem[tx_rp_r], 1'b0};
               end
            end
            TX_SHIFT: begin
               if (brk) begin
                  tx_st_r <= TX_IDLE;
               end else if (tx_tmr_r == 5'd0) begin
                  tx_tmr_r <= `BIT_LAST;
                  tx_sh_r <= {1'b1, tx_sh_r[10:1]};
                  tx_idx_r <= tx_idx_r + 4'h1;
                  if (tx_idx_r == tx_last) begin
                     tx_st_r <= TX_IDLE;
                  end
               end else begin
                  tx_tmr_r <= tx_tmr_r - 5'h01;
               end
            end
            default: tx_st_r <= TX_IDLE;
         endcase
      end
   end

   // receive sampler, mid-bit sampling after a confirmed start bit
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_st_r <= RX_HUNT;
         rx_sh_r <= 10'h000;
         rx_idx_r <= 4'h0;
         rx_tmr_r <= 5'h00;
      end else begin
         case (rx_st_r)
            RX_HUNT: begin
               if (rx_s_r) begin
                  rx_st_r <= RX_IDLE;
               end
            end
            RX_IDLE: begin
               if (!rx_s_r) begin
                  rx_st_r <= RX_BITS;
                  rx_idx_r <= 4'h0;
                  rx_tmr_r <= `BIT_MID;
               end
            end
            RX_BITS: begin
               if (rx_tmr_r != 5'd0) begin
                  rx_tmr_r <= rx_tmr_r - 5'h01;
               end else if ((rx_idx_r == 4'h0) & rx_s_r) begin
                  rx_st_r <= RX_IDLE;
               end else if (rx_done) begin
                  rx_st_r <= RX_HUNT;
               end else begin
                  rx_tmr_r <= `BIT_LAST;
                  rx_idx_r <= rx_idx_r + 4'h1;
                  if (rx_idx_r != 4'h0) begin
                     rx_sh_r <= {rx_s_r, rx_sh_r[9:1]};
                  end
               end
            end
            default: rx_st_r <= RX_HUNT;
         endcase
      end
   end

   // request pin: automatic by fill level, else the software level
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rts <= 1'b1;
         rts_oe <= 1'b0;
      end else begin
         rts_oe <= ctrl_r[`CTL_4W];
         if (ctrl_r[`CTL_AREQ]) begin
            rts <= ctrl_r[`CTL_POL] ? req_below : ~req_below;
         end else begin
            rts <= ctrl_r[`CTL_MREQ];
         end
      end
   end
endmodule

// ==== verilog/uart_flow_defs.vh ====
// register map, field positions, reset values and timing for the flow-controlled serial port
`ifndef UART_FLOW_DEFS_VH
`define UART_FLOW_DEFS_VH
// byte addresses of the register words
`define ADDR_DATA 12'h000
`define ADDR_CTRL 12'h004
`define ADDR_FLUSH 12'h008
`define ADDR_LINE 12'h00c
`define ADDR_MODEM 12'h010
`define ADDR_IDENT 12'h014
`define ADDR_LEVEL 12'h018
// control word fields
`define CTL_AREQ 0
`define CTL_ACLR 1
`define CTL_THR 2
`define CTL_POL 4
`define CTL_MREQ 5
`define CTL_BRK 6
`define CTL_4W 7
`define CTL_TRIG 8
`define CTL_PAR 10
`define CTL_IE_RX 12
`define CTL_IE_TX 13
`define CTL_IE_LINE 14
`define CTL_IE_MODEM 15
`define CTRL_RST 16'h0080
// flush word fields
`define FL_TX 0
`define FL_RX 1
// line status fields
`define LS_DR 0
`define LS_OE 1
`define LS_PE 2
`define LS_FE 3
`define LS_BI 4
`define LS_THRE 5
`define LS_TEMT 6
`define LS_ERR 7
// modem status fields
`define MS_DCTS 0
`define MS_CTS 4
// pending source codes
`define IRQ_LINE 3'h3
`define IRQ_RXAV 3'h2
`define IRQ_TOUT 3'h6
`define IRQ_TXE 3'h1
`define IRQ_MODEM 3'h0
// fifo size
`define FIFO_DEPTH 5'h10
// timing
`define CLK_NS 10
`define BIT_TIME_NS 160
`define BIT_CYC (`BIT_TIME_NS / `CLK_NS)
`define BIT_LAST 5'h0f
`define BIT_MID 5'h08
`define CHAR_BITS 11
`define TO_CHARS 4
`define TO_CYC (`TO_CHARS * `CHAR_BITS * `BIT_CYC)
`endif
